// ===== rtl/aipc_regs.sv
// Analogue input gain and path configuration registers with an Avalon-MM slave.
// Assumes a single 125 MHz clock; the master holds each request until waitrequest is low.
//
// The Avalon-MM slave port was decided locally.
`default_nettype none

module aipc_regs import aipc_pkg::*; (
  // Clock, reset, enable
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Avalon-MM slave
  input  wire logic [AIPC_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [AIPC_DATA_W-1:0] avs_writedata,
  input  wire logic [AIPC_BE_W-1:0]   avs_byteenable,
  output logic      [AIPC_DATA_W-1:0] avs_readdata,
  output logic                        avs_waitrequest,
  // Right analogue path
  output logic                        right_gain_stage_mute,
  output logic      [4:0]             right_gain_code,
  output logic signed [9:0]           right_gain_tenth_db,
  output logic                        right_gain_reserved,
  output logic      [1:0]             right_mode,
  // Left analogue path
  output logic                        left_common_reject_en,
  output logic      [1:0]             left_mode,
  output logic      [2:0]             left_inv_pin,
  output logic      [2:0]             left_noninv_pin
);

  // ****************************************
  // Bus handshake
  // ****************************************
  aipc_state_t            state_reg;
  aipc_state_t            state_next;
  logic                   wait_reg;
  logic                   wait_next;
  logic [31:0]            rdata_reg;
  logic [31:0]            rdata_next;
  logic [AIPC_IDX_W-1:0]  idx;
  logic [31:0]            rd_mux;
  logic                   commit_wr;

  assign idx       = avs_address[AIPC_ADDR_W-1:2];
  assign commit_wr = (state_reg == AIPC_ST_ACK) && avs_write && avs_byteenable[0];

  // ****************************************
  // Fields
  // ****************************************
  logic       mute_reg,  mute_next;
  logic [4:0] gain_reg,  gain_next;
  logic       cmr_reg,   cmr_next;
  logic [1:0] sel1_reg,  sel1_next;
  logic [1:0] sel2_reg,  sel2_next;
  logic [1:0] lmode_reg, lmode_next;
  logic [1:0] rmode_reg, rmode_next;

  // Read multiplexer: unassigned bits and unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      AIPC_IDX_RIGHT_GAIN: begin
        rd_mux[AIPC_MUTE_BIT]                        = mute_reg;
        rd_mux[AIPC_GAIN_LSB +: AIPC_GAIN_W]         = gain_reg;
      end
      AIPC_IDX_LEFT_CFG: begin
        rd_mux[AIPC_CMR_BIT]                         = cmr_reg;
        rd_mux[AIPC_SEL1_LSB +: AIPC_SEL_W]          = sel1_reg;
        rd_mux[AIPC_SEL2_LSB +: AIPC_SEL_W]          = sel2_reg;
        rd_mux[AIPC_MODE_LSB +: AIPC_MODE_W]         = lmode_reg;
      end
      AIPC_IDX_RIGHT_MODE: begin
        rd_mux[AIPC_MODE_LSB +: AIPC_MODE_W]         = rmode_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Answer one cycle after a request appears, then drop the answer
  always_comb begin
    state_next = state_reg;
    wait_next  = wait_reg;
    rdata_next = rdata_reg;
    unique case (state_reg)
      AIPC_ST_IDLE: begin
        if (avs_read || avs_write) begin
          state_next = AIPC_ST_ACK;
          wait_next  = 1'b0;
          rdata_next = avs_read ? rd_mux : 32'h0000_0000;
        end
      end
      AIPC_ST_ACK: begin
        state_next = AIPC_ST_IDLE;
        wait_next  = 1'b1;
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= AIPC_ST_IDLE;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  // ****************************************
  // Write decode at the accepting edge
  // ****************************************
  logic wr_right;
  logic wr_left;
  logic wr_rmode;

  always_comb begin
    wr_right = 1'b0;
    wr_left  = 1'b0;
    wr_rmode = 1'b0;
    if (commit_wr) begin
      unique case (idx)
        AIPC_IDX_RIGHT_GAIN: begin
          wr_right = 1'b1;
        end
        AIPC_IDX_LEFT_CFG: begin
          wr_left  = 1'b1;
        end
        AIPC_IDX_RIGHT_MODE: begin
          wr_rmode = 1'b1;
        end
        default: begin
          wr_right = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Right gain and mute register
  // ****************************************
  always_comb begin
    mute_next = mute_reg;
    gain_next = gain_reg;
    if (wr_right) begin
      mute_next = avs_writedata[AIPC_MUTE_BIT];
      gain_next = avs_writedata[AIPC_GAIN_LSB +: AIPC_GAIN_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mute_reg <= AIPC_RST_MUTE;
      gain_reg <= AIPC_RST_GAIN;
    end else if (ce) begin
      mute_reg <= mute_next;
      gain_reg <= gain_next;
    end
  end

  // ****************************************
  // Left path configuration register
  // ****************************************
  always_comb begin
    cmr_next   = cmr_reg;
    sel1_next  = sel1_reg;
    sel2_next  = sel2_reg;
    lmode_next = lmode_reg;
    if (wr_left) begin
      cmr_next   = avs_writedata[AIPC_CMR_BIT];
      sel1_next  = avs_writedata[AIPC_SEL1_LSB +: AIPC_SEL_W];
      sel2_next  = avs_writedata[AIPC_SEL2_LSB +: AIPC_SEL_W];
      lmode_next = avs_writedata[AIPC_MODE_LSB +: AIPC_MODE_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmr_reg   <= AIPC_RST_CMR;
      sel1_reg  <= AIPC_RST_SEL1;
      sel2_reg  <= AIPC_RST_SEL2;
      lmode_reg <= AIPC_RST_MODE;
    end else if (ce) begin
      cmr_reg   <= cmr_next;
      sel1_reg  <= sel1_next;
      sel2_reg  <= sel2_next;
      lmode_reg <= lmode_next;
    end
  end

  // ****************************************
  // Right mode register
  // ****************************************
  always_comb begin
    rmode_next = rmode_reg;
    if (wr_rmode) begin
      rmode_next = avs_writedata[AIPC_MODE_LSB +: AIPC_MODE_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rmode_reg <= AIPC_RST_MODE;
    end else if (ce) begin
      rmode_reg <= rmode_next;
    end
  end

  // ****************************************
  // Analogue path outputs, from next field values
  // ****************************************
  aipc_gain_if gif ();

  assign gif.code = gain_next;
  assign gif.mode = rmode_next;

  aipc_gain_decode u_decode (
    .gif (gif)
  );

  logic              out_mute_next;
  logic [4:0]        out_code_next;
  logic signed [9:0] out_db_next;
  logic              out_rsv_next;
  logic [1:0]        out_rmode_next;
  logic              out_cmr_next;
  logic [1:0]        out_lmode_next;
  logic [2:0]        pin1_hot;
  logic [2:0]        pin2_hot;
  logic [2:0]        out_inv_next;
  logic [2:0]        out_noninv_next;

  // Pin code 00 first pin, 01 second pin, 1x third pin
  function automatic logic [2:0] pin_onehot(input logic [1:0] sel);
    logic [2:0] hot;
    hot = 3'h0;
    if (sel[1]) begin
      hot = 3'h4;
    end else if (sel[0]) begin
      hot = 3'h2;
    end else begin
      hot = 3'h1;
    end
    return hot;
  endfunction

  // Reset routing and enable follow the reset field codes
  localparam logic [2:0] LEFT_INV_RST    = pin_onehot(AIPC_RST_SEL1);
  localparam logic [2:0] LEFT_NONINV_RST = pin_onehot(AIPC_RST_SEL2);
  localparam logic       LEFT_CMR_RST    = AIPC_RST_CMR && (AIPC_RST_MODE == AIPC_MODE_DIFF_LN);

  // Right path outputs
  always_comb begin
    out_mute_next  = mute_next;
    out_code_next  = gain_next;
    out_db_next    = gif.tenth_db;
    out_rsv_next   = gif.reserved;
    out_rmode_next = rmode_next;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      right_gain_stage_mute <= AIPC_RST_MUTE;
      right_gain_code       <= AIPC_RST_GAIN;
      right_gain_tenth_db   <= AIPC_LINE_GAIN[AIPC_RST_GAIN];
      right_gain_reserved   <= 1'b0;
      right_mode            <= AIPC_RST_MODE;
    end else if (ce) begin
      right_gain_stage_mute <= out_mute_next;
      right_gain_code       <= out_code_next;
      right_gain_tenth_db   <= out_db_next;
      right_gain_reserved   <= out_rsv_next;
      right_mode            <= out_rmode_next;
    end
  end

  // Left path outputs; mic mode swaps the selectors between the sides
  always_comb begin
    pin1_hot        = pin_onehot(sel1_next);
    pin2_hot        = pin_onehot(sel2_next);
    out_lmode_next  = lmode_next;
    out_cmr_next    = cmr_next && (lmode_next == AIPC_MODE_DIFF_LN);
    if (lmode_next == AIPC_MODE_DIFF_MIC) begin
      out_inv_next    = pin2_hot;
      out_noninv_next = pin1_hot;
    end else begin
      out_inv_next    = pin1_hot;
      out_noninv_next = pin2_hot;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_common_reject_en <= LEFT_CMR_RST;
      left_mode             <= AIPC_RST_MODE;
      left_inv_pin          <= LEFT_INV_RST;
      left_noninv_pin       <= LEFT_NONINV_RST;
    end else if (ce) begin
      left_common_reject_en <= out_cmr_next;
      left_mode             <= out_lmode_next;
      left_inv_pin          <= out_inv_next;
      left_noninv_pin       <= out_noninv_next;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/aipc_pkg.sv
// Constants, field layout and types of the analogue input configuration bank.
// Assumes a 125 MHz system clock and an Avalon-MM master with byte addresses.
//
// What this block does
// - Right gain-stage mute at bit 7, resets to 1; 1 mutes, 0 unmutes.
// - Five-bit right gain code at bits 4:0, resets to 00101.
// - Single-ended or line mode: 32 codes decode nonlinearly, -1.5 dB to +28.3 dB.
// - Mic mode: code 0 reserved, 1..6 give +12..+27 dB, 7..31 give +30 dB.
// - Left common-reject enable at bit 6, resets 1, effective only in line mode.
// - Left first pin select bits 5:4, reset 00; inverting, non-inverting in mic mode.
// - Left second pin select bits 3:2, reset 01; non-inverting, inverting in mic mode.
// - Left mode bits 1:0, reset 00: single-ended, line, mic, 11 reserved.
// - Right mode selects right gain decode: single-ended, line, mic, 11 reserved.
`default_nettype none

package aipc_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int unsigned AIPC_ADDR_W   = 10;
  localparam int unsigned AIPC_DATA_W   = 32;
  localparam int unsigned AIPC_BE_W     = 4;
  localparam int unsigned AIPC_IDX_W    = 8;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [7:0]  AIPC_IDX_RIGHT_GAIN = 8'h2d;
  localparam logic [7:0]  AIPC_IDX_LEFT_CFG   = 8'h2e;
  localparam logic [7:0]  AIPC_IDX_RIGHT_MODE = 8'h2f;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned AIPC_MUTE_BIT       = 7;
  localparam int unsigned AIPC_GAIN_LSB       = 0;
  localparam int unsigned AIPC_GAIN_W         = 5;
  localparam int unsigned AIPC_CMR_BIT        = 6;
  localparam int unsigned AIPC_SEL1_LSB       = 4;
  localparam int unsigned AIPC_SEL2_LSB       = 2;
  localparam int unsigned AIPC_MODE_LSB       = 0;
  localparam int unsigned AIPC_SEL_W          = 2;
  localparam int unsigned AIPC_MODE_W         = 2;
  localparam int unsigned AIPC_DB_W           = 10;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic        AIPC_RST_MUTE       = 1'h1;
  localparam logic [4:0]  AIPC_RST_GAIN       = 5'h05;
  localparam logic        AIPC_RST_CMR        = 1'h1;
  localparam logic [1:0]  AIPC_RST_SEL1       = 2'h0;
  localparam logic [1:0]  AIPC_RST_SEL2       = 2'h1;
  localparam logic [1:0]  AIPC_RST_MODE       = 2'h0;

  // ****************************************
  // Input modes and gain tables (tenths of a dB)
  // ****************************************
  typedef enum logic [1:0] {
    AIPC_MODE_SINGLE   = 2'h0,
    AIPC_MODE_DIFF_LN  = 2'h1,
    AIPC_MODE_DIFF_MIC = 2'h2,
    AIPC_MODE_RSVD     = 2'h3
  } aipc_mode_t;

  localparam logic signed [9:0] AIPC_LINE_GAIN [32] = '{
    -10'sd15, -10'sd13, -10'sd10, -10'sd7, -10'sd3, 10'sd0, 10'sd3, 10'sd7,
    10'sd10, 10'sd14, 10'sd18, 10'sd23, 10'sd27, 10'sd32, 10'sd37, 10'sd42,
    10'sd48, 10'sd54, 10'sd60, 10'sd67, 10'sd75, 10'sd83, 10'sd92, 10'sd102,
    10'sd114, 10'sd127, 10'sd143, 10'sd162, 10'sd192, 10'sd223, 10'sd252, 10'sd283
  };
  localparam logic signed [9:0] AIPC_MIC_BASE     = 10'sd120;
  localparam logic signed [9:0] AIPC_MIC_STEP     = 10'sd30;
  localparam logic signed [9:0] AIPC_MIC_MAX      = 10'sd300;
  localparam logic [4:0]        AIPC_MIC_SAT_CODE = 5'h07;

  // Bus handshake states
  typedef enum logic [1:0] {
    AIPC_ST_IDLE = 2'b01,
    AIPC_ST_ACK  = 2'b10
  } aipc_state_t;

endpackage

`default_nettype wire

// ===== rtl/aipc_gain_if.sv
// Carrier between the register bank and its right gain decoder.
// Assumes both ends sit in the same clock domain; all signals are combinational.
`default_nettype none

interface aipc_gain_if import aipc_pkg::*;;
  logic [4:0]        code;
  logic [1:0]        mode;
  logic signed [9:0] tenth_db;
  logic              reserved;

  modport bank   (output code, output mode, input tenth_db, input reserved);
  modport decode (input code, input mode, output tenth_db, output reserved);
endinterface

`default_nettype wire

// ===== rtl/aipc_gain_decode.sv
// Right input gain decoder: gain code and mode to gain in tenths of a dB.
// Assumes its inputs come from the next-state logic of the register bank.
`default_nettype none

module aipc_gain_decode import aipc_pkg::*; (
  // Decode carrier
  aipc_gain_if.decode gif
);

  logic [4:0] step;

  always_comb begin
    step         = gif.code - 5'h01;
    gif.tenth_db = 10'sd0;
    gif.reserved = 1'b0;
    unique case (gif.mode)
      AIPC_MODE_SINGLE, AIPC_MODE_DIFF_LN: begin
        gif.tenth_db = AIPC_LINE_GAIN[gif.code];
      end
      AIPC_MODE_DIFF_MIC: begin
        if (gif.code == 5'h00) begin
          gif.reserved = 1'b1;
        end else if (gif.code >= AIPC_MIC_SAT_CODE) begin
          gif.tenth_db = AIPC_MIC_MAX;
        end else begin
          gif.tenth_db = AIPC_MIC_BASE + AIPC_MIC_STEP * $signed({5'h00, step});
        end
      end
      default: begin
        gif.reserved = 1'b1;
      end
    endcase
  end

endmodule

`default_nettype wire

// ===== sim/aipc_regs_assertions.sv
// Concurrent checks on the ports of the analogue input configuration bank.
// Assumes it is bound to aipc_regs; one clock, rst asynchronous and active high.
`default_nettype none

module aipc_regs_assertions import aipc_pkg::*; (
  // Clock, reset, enable
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   ce,
  // Avalon-MM slave
  input wire logic [AIPC_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [AIPC_DATA_W-1:0] avs_writedata,
  input wire logic [AIPC_BE_W-1:0]   avs_byteenable,
  input wire logic [AIPC_DATA_W-1:0] avs_readdata,
  input wire logic                   avs_waitrequest,
  // Analogue paths
  input wire logic                   right_gain_stage_mute,
  input wire logic [4:0]             right_gain_code,
  input wire logic signed [9:0]      right_gain_tenth_db,
  input wire logic                   right_gain_reserved,
  input wire logic [1:0]             right_mode,
  input wire logic                   left_common_reject_en,
  input wire logic [1:0]             left_mode,
  input wire logic [2:0]             left_inv_pin,
  input wire logic [2:0]             left_noninv_pin
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [7:0] wd_q;
  logic       wr_done;
  always_ff @(posedge clk) begin
    wd_q <= avs_writedata[7:0];
  end
  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************************************
  // Assertions
  // ****************************************
  a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_rdata: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  a_right_rdback: assert property (avs_read && !avs_waitrequest && avs_address[9:2] == AIPC_IDX_RIGHT_GAIN
    |-> avs_readdata == {24'h0, right_gain_stage_mute, 2'h0, right_gain_code})
    else $error("right gain read back wrong");
  a_right_commit: assert property (wr_done && avs_address[9:2] == AIPC_IDX_RIGHT_GAIN
    |=> right_gain_code == wd_q[4:0] && right_gain_stage_mute == wd_q[7])
    else $error("right gain write not applied");
  a_left_commit: assert property (wr_done && avs_address[9:2] == AIPC_IDX_LEFT_CFG
    |=> left_mode == wd_q[1:0])
    else $error("left mode write not applied");
  a_cmr_gated: assert property (left_common_reject_en |-> left_mode == 2'h1)
    else $error("common reject enabled outside line mode");
  a_pin_onehot: assert property ($onehot(left_inv_pin) && $onehot(left_noninv_pin))
    else $error("pin select not one-hot");
  a_line_table: assert property (right_mode[1] == 1'h0
    |-> right_gain_tenth_db == AIPC_LINE_GAIN[right_gain_code])
    else $error("line gain decode wrong");
  a_mic_sat: assert property (right_mode == 2'h2 && right_gain_code >= 5'h07
    |-> right_gain_tenth_db == 10'sd300 && !right_gain_reserved)
    else $error("mic gain not saturated");

  // ****************************************
  // Covers
  // ****************************************
  c_write: cover property (wr_done);
  c_reserved: cover property (right_gain_reserved);
  c_cmr: cover property (left_common_reject_en);
endmodule

`default_nettype wire

// ===== sim/aipc_regs_tb.sv
// Self-checking bench for the analogue input configuration bank.
// Assumes aipc_pkg and aipc_regs are compiled first; drives Avalon-MM itself.
`default_nettype none

module aipc_regs_tb import aipc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk = 1'h0;
  logic                   rst;
  logic                   ce;
  logic [AIPC_ADDR_W-1:0] avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [AIPC_DATA_W-1:0] avs_writedata;
  logic [AIPC_BE_W-1:0]   avs_byteenable;
  logic [AIPC_DATA_W-1:0] avs_readdata;
  logic                   avs_waitrequest;
  logic                   right_gain_stage_mute;
  logic [4:0]             right_gain_code;
  logic signed [9:0]      right_gain_tenth_db;
  logic                   right_gain_reserved;
  logic [1:0]             right_mode;
  logic                   left_common_reject_en;
  logic [1:0]             left_mode;
  logic [2:0]             left_inv_pin;
  logic [2:0]             left_noninv_pin;
  int                     n_errors = 0;
  int                     n_tests  = 0;
  int                     cyc      = 0;
  logic [31:0]            q;
  logic [6:0]             v;
  int                     e;

  always #4 clk = ~clk;

  aipc_regs u_dut (
    .clk                   (clk),
    .rst                   (rst),
    .ce                    (ce),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_byteenable        (avs_byteenable),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .right_gain_stage_mute (right_gain_stage_mute),
    .right_gain_code       (right_gain_code),
    .right_gain_tenth_db   (right_gain_tenth_db),
    .right_gain_reserved   (right_gain_reserved),
    .right_mode            (right_mode),
    .left_common_reject_en (left_common_reject_en),
    .left_mode             (left_mode),
    .left_inv_pin          (left_inv_pin),
    .left_noninv_pin       (left_noninv_pin)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Called right after a rising edge; holds until waitrequest is sampled low; the caller releases it
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
    avs_address <= {idx, 2'h0};
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
  endtask

  task automatic settle;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'h0, idx, 32'h0, 4'hf);
    chk(q, exp);
  endtask

  function automatic logic [2:0] pin(input int s);
    return (s > 1) ? 3'h4 : (s == 1) ? 3'h2 : 3'h1;
  endfunction

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    avs_address = '0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = '0;
    avs_byteenable = '0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    settle();
    chk(32'(right_gain_stage_mute), 32'h1);
    chk(32'(right_gain_code), 32'h5);
    chk({left_inv_pin, left_noninv_pin, left_common_reject_en}, 32'h14);
    rd(8'h2d, 32'h85);
    rd(8'h2e, 32'h44);
    rd(8'h2f, 32'h0);
    for (int m = 0; m < 4; m++) begin
      bus(1'h1, 8'h2f, 32'(m), 4'hf);
      for (int c = 0; c < 32; c++) begin
        bus(1'h1, 8'h2d, {24'h0, 1'(c), 2'h3, 5'(c)}, 4'hf);
        settle();
        e = (m < 2) ? int'(AIPC_LINE_GAIN[c]) : (m == 3 || c == 0) ? 0 : (c < 7) ? 90 + 30 * c : 300;
        chk(32'(right_gain_tenth_db), 32'(e));
        chk(32'(right_gain_reserved), 32'(m == 3 || (m == 2 && c == 0)));
        chk({right_mode, right_gain_stage_mute, right_gain_code}, 32'((m << 6) | ((c & 1) << 5) | c));
        rd(8'h2d, 32'(((c & 1) << 7) | c));
      end
    end
    for (int i = 0; i < 64; i++) begin
      v = 7'(((((i >> 4) ^ (i >> 2)) & 1) << 6) | i);
      bus(1'h1, 8'h2e, {24'hffffff, 1'h1, v}, 4'hf);
      settle();
      chk(32'(left_mode), 32'(i & 3));
      chk(32'(left_common_reject_en), 32'(v[6] && (i & 3) == 1));
      chk(32'(left_inv_pin), 32'(((i & 3) == 2) ? pin((i >> 2) & 3) : pin(i >> 4)));
      chk(32'(left_noninv_pin), 32'(((i & 3) == 2) ? pin(i >> 4) : pin((i >> 2) & 3)));
      rd(8'h2e, {25'h0, v});
    end
    bus(1'h1, 8'h2d, 32'h0, 4'he);
    rd(8'h2d, 32'h9f);
    bus(1'h1, 8'h30, 32'hffffffff, 4'hf);
    rd(8'h30, 32'h0);
    bus(1'h1, 8'h2f, 32'hffffffff, 4'hf);
    rd(8'h2f, 32'h3);
    settle();
    ce <= 1'h0;
    fork
      bus(1'h1, 8'h2d, 32'h0, 4'hf);
      begin
        repeat (3) @(posedge clk);
        chk(32'(avs_waitrequest), 32'h1);
        chk({right_gain_stage_mute, right_gain_code}, 32'h3f);
        ce <= 1'h1;
      end
    join
    settle();
    chk({right_gain_stage_mute, right_gain_code}, 32'h0);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk({right_mode, right_gain_stage_mute, right_gain_code}, 32'h25);
    chk({left_inv_pin, left_noninv_pin, left_common_reject_en}, 32'h14);
    rd(8'h2d, 32'h85);
    rd(8'h2f, 32'h0);
    settle();
    end_sim();
  end
endmodule

bind aipc_regs aipc_regs_assertions u_chk (.clk, .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .right_gain_stage_mute, .right_gain_code, .right_gain_tenth_db,
  .right_gain_reserved, .right_mode, .left_common_reject_en, .left_mode, .left_inv_pin, .left_noninv_pin);

`default_nettype wire
